// [rtl/wdcu_pkg.sv]
// package: register map, field positions, reset values and timing of the watchdog unit
package wdcu_pkg;
    // ***************************************************
    // register byte addresses
    // ***************************************************
    localparam logic [11:0] WDCU_OFS_CONTROL = 12'h0D8;
    localparam logic [11:0] WDCU_OFS_IRQ_ENABLE = 12'h0E8;
    localparam logic [11:0] WDCU_OFS_IRQ_PRIORITY = 12'h0F8;
    localparam logic [11:0] WDCU_OFS_KEY = 12'h0C7;
    localparam logic [11:0] WDCU_OFS_CLOCK_CONTROL = 12'h08E;
    localparam logic [11:0] WDCU_OFS_RESET_CTRL = 12'h100;
    localparam logic [11:0] WDCU_OFS_EVT_STATUS = 12'h104;
    localparam logic [11:0] WDCU_OFS_EVT_ENABLE = 12'h108;
    localparam logic [11:0] WDCU_OFS_EVT_CLEAR = 12'h10C;
    // ***************************************************
    // watchdog control field positions
    // ***************************************************
    localparam int WDCU_BIT_RESTART = 0;
    localparam int WDCU_BIT_RST_EN = 1;
    localparam int WDCU_BIT_CAUSE = 2;
    localparam int WDCU_BIT_TIMEOUT = 3;
    localparam int WDCU_BIT_POWER_ON = 6;
    localparam int WDCU_BIT_IRQ_EN = 4;
    localparam int WDCU_BIT_IRQ_PRIO = 4;
    // bits writable only inside the key window
    localparam logic [7:0] WDCU_PROT_MASK = 8'h4B;
    // bits that an external reset forces to zero
    localparam logic [7:0] WDCU_EXT_CLR_MASK = 8'hA9;
    localparam logic [7:0] WDCU_IRQEN_RSVD = 8'hE0;
    // ***************************************************
    // reset values and keys
    // ***************************************************
    localparam logic [7:0] WDCU_CONTROL_POR = 8'h40;
    localparam logic [7:0] WDCU_KEY_FIRST = 8'hAA;
    localparam logic [7:0] WDCU_KEY_SECOND = 8'h55;
    localparam logic [1:0] WDCU_EVT_RESET = 2'h0;
    // ***************************************************
    // timing
    // ***************************************************
    localparam int WDCU_CLK_PER_MC = 4;
    localparam int WDCU_WINDOW_MC = 3;
    localparam logic [3:0] WDCU_WINDOW_CYC = 4'(WDCU_CLK_PER_MC * WDCU_WINDOW_MC);
    localparam int WDCU_RESET_DELAY_CLK = 512;
    localparam logic [9:0] WDCU_RESET_DELAY_CYC = 10'(WDCU_RESET_DELAY_CLK);
    localparam int WDCU_CNT_W = 26;
    localparam logic [4:0] WDCU_INTERVAL_BITS_0 = 5'd16;
    localparam logic [4:0] WDCU_INTERVAL_BITS_1 = 5'd20;
    localparam logic [4:0] WDCU_INTERVAL_BITS_2 = 5'd23;
    localparam logic [4:0] WDCU_INTERVAL_BITS_3 = 5'd26;
    // ***************************************************
    // carriers
    // ***************************************************
    typedef struct packed {
        logic sel;
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
    } wdcu_req_t;
    typedef struct packed {
        logic power_on;
        logic timeout;
        logic cause;
        logic rst_en;
        logic restart;
    } wdcu_ctrl_t;
endpackage

// [rtl/wdcu_key_gate.sv]
// timed-access key sequence and protected write window
`timescale 1ns/10ps
module wdcu_key_gate
    import wdcu_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic key_wr,
    input wire logic other_wr,
    input wire logic [7:0] key_data,
    output logic window_open
);
    logic armed_reg;
    logic [3:0] win_cnt_reg;
    wire first_hit = key_wr && (key_data == WDCU_KEY_FIRST);
    wire second_hit = key_wr && armed_reg && (key_data == WDCU_KEY_SECOND);
    assign window_open = (win_cnt_reg != 4'h0);
    // AA arms, an immediate 55 opens; any other write disarms
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            armed_reg <= 1'b0;
            win_cnt_reg <= 4'h0;
        end
        else
        begin
            // only the very next write may carry the second key
            if (key_wr || other_wr)
                armed_reg <= first_hit;
            if (second_hit)
                win_cnt_reg <= WDCU_WINDOW_CYC;
            else if (window_open)
                win_cnt_reg <= win_cnt_reg - 4'h1;
        end
    end
endmodule

// [rtl/wdcu_dog_counter.sv]
// free-running watchdog counter with selectable interval
`timescale 1ns/10ps
module wdcu_dog_counter
    import wdcu_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic [1:0] interval_sel,
    output logic timeout_pulse
);
    logic [WDCU_CNT_W-1:0] cnt_reg;
    logic [WDCU_CNT_W:0] sum;
    logic [4:0] width_sel;
    logic [WDCU_CNT_W-1:0] top_mask;
    assign sum = {1'b0, cnt_reg} + {{WDCU_CNT_W{1'b0}}, 1'b1};
    assign width_sel = (interval_sel == 2'h3) ? WDCU_INTERVAL_BITS_3 :
                       (interval_sel == 2'h2) ? WDCU_INTERVAL_BITS_2 :
                       (interval_sel == 2'h1) ? WDCU_INTERVAL_BITS_1 : WDCU_INTERVAL_BITS_0;
    assign top_mask = WDCU_CNT_W'((27'h1 << width_sel) - 27'h1);
    // time-out on the carry out of the selected bit
    assign timeout_pulse = !clear && ((cnt_reg & top_mask) == top_mask);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= '0;
        else if (clear)
            cnt_reg <= '0;
        else
            cnt_reg <= sum[WDCU_CNT_W-1:0] & top_mask;
    end
endmodule

// [rtl/wdcu_top.sv]
// watchdog control unit: registers, reset causes, interrupt-then-reset sequence
// ***************************************************
// ***************************************************
`timescale 1ns/10ps
module wdcu_top
    import wdcu_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ext_reset_pulse,
    input wire logic power_fail_reset_pulse,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic dog_irq,
    output logic dog_irq_high_prio,
    output logic dog_reset_out,
    output logic evt_irq
);
    // ***************************************************
    // bus decode
    // ***************************************************
    wdcu_req_t req;
    assign req.sel = psel && penable;
    assign req.wr = pwrite;
    assign req.addr = paddr;
    assign req.wdata = pwdata[7:0];
    wire wr_en = req.sel && req.wr;
    wire hit_ctrl = (req.addr == WDCU_OFS_CONTROL);
    wire hit_ie = (req.addr == WDCU_OFS_IRQ_ENABLE);
    wire hit_ip = (req.addr == WDCU_OFS_IRQ_PRIORITY);
    wire hit_key = (req.addr == WDCU_OFS_KEY);
    wire hit_ck = (req.addr == WDCU_OFS_CLOCK_CONTROL);
    wire hit_rc = (req.addr == WDCU_OFS_RESET_CTRL);
    wire hit_st = (req.addr == WDCU_OFS_EVT_STATUS);
    wire hit_en = (req.addr == WDCU_OFS_EVT_ENABLE);
    wire hit_cl = (req.addr == WDCU_OFS_EVT_CLEAR);
    wire mapped = hit_ctrl | hit_ie | hit_ip | hit_key | hit_ck | hit_rc | hit_st | hit_en | hit_cl;
    assign pready = 1'b1;
    assign pslverr = req.sel && !mapped;
    // ***************************************************
    // registers
    // ***************************************************
    wdcu_ctrl_t ctrl_reg;
    logic [7:0] ctrl_free_reg;
    logic [7:0] ie_reg;
    logic [7:0] ip_reg;
    logic [7:0] ck_reg;
    logic [9:0] delay_reg;
    logic pending_reg;
    logic dog_rst_reg;
    logic [1:0] evt_st_reg;
    logic [1:0] evt_en_reg;
    logic window_open;
    logic timeout_pulse;
    wdcu_ctrl_t ctrl_next;
    // ***************************************************
    // submodules
    // ***************************************************
    wdcu_key_gate u_key
    (
        .pclk(pclk),
        .presetn(presetn),
        .key_wr(wr_en && hit_key),
        .other_wr(wr_en && !hit_key),
        .key_data(req.wdata),
        .window_open(window_open)
    );
    wdcu_dog_counter u_cnt
    (
        .pclk(pclk),
        .presetn(presetn),
        .clear(ctrl_reg.restart || dog_rst_reg || ext_reset_pulse),
        .interval_sel(ck_reg[7:6]),
        .timeout_pulse(timeout_pulse)
    );
    // ***************************************************
    // control register next value
    // ***************************************************
    wire ctrl_wr = wr_en && hit_ctrl;
    // bits held in ctrl_reg, kept out of the free byte
    wire [7:0] ctrl_hw_bits = WDCU_PROT_MASK | 8'(1 << WDCU_BIT_CAUSE);
    wire prot_ok = ctrl_wr && window_open;
    wire fire = pending_reg && (delay_reg == 10'h001);
    wire dog_reset_now = fire && ctrl_reg.rst_en;
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (prot_ok)
        begin
            ctrl_next.power_on = req.wdata[WDCU_BIT_POWER_ON];
            ctrl_next.rst_en = req.wdata[WDCU_BIT_RST_EN];
            ctrl_next.timeout = req.wdata[WDCU_BIT_TIMEOUT];
            ctrl_next.restart = req.wdata[WDCU_BIT_RESTART];
        end
        else
            ctrl_next.restart = 1'b0;
        if (ctrl_wr)
            ctrl_next.cause = req.wdata[WDCU_BIT_CAUSE];
        if (timeout_pulse)
            ctrl_next.timeout = 1'b1;
        if (dog_reset_now)
            ctrl_next.cause = 1'b1;
        if (power_fail_reset_pulse)
            ctrl_next.cause = 1'b0;
        // reset enable is left alone by an external reset
        if (ext_reset_pulse)
        begin
            ctrl_next.timeout = 1'b0;
            ctrl_next.restart = 1'b0;
        end
    end
    // ***************************************************
    // sequential state
    // ***************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= '0;
            ctrl_reg.power_on <= 1'b1;
            ctrl_free_reg <= 8'h00;
            ie_reg <= 8'h00;
            ip_reg <= 8'h00;
            ck_reg <= 8'h00;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            if (ext_reset_pulse)
                ctrl_free_reg <= ctrl_free_reg & ~WDCU_EXT_CLR_MASK;
            else if (ctrl_wr)
                ctrl_free_reg <= req.wdata & ~ctrl_hw_bits;
            if (wr_en && hit_ie)
                ie_reg <= req.wdata;
            if (wr_en && hit_ip)
                ip_reg <= req.wdata;
            if (wr_en && hit_ck)
                ck_reg <= req.wdata;
        end
    end
    // interrupt, then reset after the delay
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pending_reg <= 1'b0;
            delay_reg <= 10'h000;
            dog_rst_reg <= 1'b0;
        end
        else
        begin
            dog_rst_reg <= dog_reset_now;
            if (ctrl_reg.restart || ext_reset_pulse || fire)
                pending_reg <= 1'b0;
            else if (timeout_pulse)
            begin
                pending_reg <= 1'b1;
                delay_reg <= WDCU_RESET_DELAY_CYC;
            end
            else if (pending_reg)
                delay_reg <= delay_reg - 10'h001;
        end
    end
    // ***************************************************
    // event status, enable, clear
    // ***************************************************
    wire [1:0] evt_set = {dog_reset_now, timeout_pulse};
    wire [1:0] evt_clr = (wr_en && hit_cl) ? req.wdata[1:0] : 2'h0;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            evt_st_reg <= WDCU_EVT_RESET;
            evt_en_reg <= WDCU_EVT_RESET;
        end
        else
        begin
            evt_st_reg <= (evt_st_reg & ~evt_clr) | evt_set;
            if (wr_en && hit_en)
                evt_en_reg <= req.wdata[1:0];
        end
    end
    assign evt_irq = |(evt_st_reg & evt_en_reg);
    // ***************************************************
    // outputs and read mux
    // ***************************************************
    wire irq_req = ctrl_reg.timeout && ie_reg[WDCU_BIT_IRQ_EN];
    assign dog_irq = irq_req;
    assign dog_irq_high_prio = irq_req && ip_reg[WDCU_BIT_IRQ_PRIO];
    assign dog_reset_out = dog_rst_reg;
    wire [7:0] ctrl_rd = ctrl_free_reg | {1'b0, ctrl_reg.power_on, 2'b00, ctrl_reg.timeout,
                         ctrl_reg.cause, ctrl_reg.rst_en, ctrl_reg.restart};
    wire [7:0] rd_byte = hit_ctrl ? ctrl_rd :
                         hit_ie ? (ie_reg | WDCU_IRQEN_RSVD) :
                         hit_ip ? ip_reg :
                         hit_ck ? ck_reg :
                         hit_rc ? {7'h00, window_open} :
                         hit_st ? {6'h00, evt_st_reg} :
                         hit_en ? {6'h00, evt_en_reg} : 8'h00;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= {24'h000000, rd_byte};
    end
endmodule

// [testbench/wdcu_asserts.sv]
// checker: port assertions of the watchdog unit
`timescale 1ns/10ps
module wdcu_checker
    import wdcu_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ext_reset_pulse,
    input wire logic power_fail_reset_pulse,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic dog_irq,
    input wire logic dog_irq_high_prio,
    input wire logic dog_reset_out,
    input wire logic evt_irq
);
    // ***************************************************
    // access sequences and properties
    // ***************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc(logic [11:0] a, logic w);
        psel && penable && pwrite == w && paddr == a;
    endsequence
    a_rsvd_read_ones: assert property (s_acc(WDCU_OFS_IRQ_ENABLE, 1'b0) |-> prdata[7:5] == 3'h7)
        else $error("reserved enable bits not ones");
    a_irq_needs_enable: assert property (s_acc(WDCU_OFS_IRQ_ENABLE, 1'b1) ##0 !pwdata[4] |=> !dog_irq)
        else $error("interrupt passes while disabled");
    a_prio_needs_bit: assert property (s_acc(WDCU_OFS_IRQ_PRIORITY, 1'b1) ##0 !pwdata[4] |=> !dog_irq_high_prio)
        else $error("high level while priority bit low");
    a_prio_with_irq: assert property (dog_irq_high_prio |-> dog_irq)
        else $error("high level without interrupt");
    a_flag_sticky: assert property (dog_irq && !psel && !ext_reset_pulse && !power_fail_reset_pulse
        && !dog_reset_out |=> dog_irq)
        else $error("timeout flag dropped by itself");
    a_reset_pulse_once: assert property ($rose(dog_reset_out) |=> !dog_reset_out [*8])
        else $error("watchdog reset pulse too long");
    a_slverr_in_access: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access");
    a_read_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0 && pready)
        else $error("read word upper bits or ready wrong");
endmodule
bind wdcu_top wdcu_checker wdcu_checker_i (.pclk(pclk), .presetn(presetn),
    .ext_reset_pulse(ext_reset_pulse), .power_fail_reset_pulse(power_fail_reset_pulse),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dog_irq(dog_irq),
    .dog_irq_high_prio(dog_irq_high_prio), .dog_reset_out(dog_reset_out), .evt_irq(evt_irq));

// [testbench/test_watchdog_control_unit.sv]
// testbench: registers, key window, time-out sequence and reset causes
`timescale 1ns/10ps
module test_watchdog_control_unit;
    import wdcu_pkg::*;
    // ***************************************************
    // signals, tasks and sequence
    // ***************************************************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ext_reset_pulse = 1'b0;
    logic power_fail_reset_pulse = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdv;
    logic pready, pslverr, dog_irq, dog_irq_high_prio, dog_reset_out, evt_irq, errv;
    logic [7:0] d;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int t;
    int lim;
    wdcu_top wdcu_top_i (.pclk(pclk), .presetn(presetn), .ext_reset_pulse(ext_reset_pulse),
        .power_fail_reset_pulse(power_fail_reset_pulse), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dog_irq(dog_irq), .dog_irq_high_prio(dog_irq_high_prio),
        .dog_reset_out(dog_reset_out), .evt_irq(evt_irq));
    initial
    begin
        forever #2 pclk = ~pclk;
    end
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // control byte after an external reset: only bits 6, 4, 2 and 1 survive
    function automatic logic [7:0] after_ext_reset(input logic [7:0] v);
        return v & 8'h56;
    endfunction
    // one apb transfer; keep leaves psel up for a following setup, else one idle edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] v, input bit keep);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, v};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        if (!keep)
        begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input logic [7:0] m);
        xfer(1'b0, a, 8'h00, 1'b0);
        check(rdv & {24'h0, m}, {24'h0, exp});
    endtask
    task automatic unlock();
        xfer(1'b1, WDCU_OFS_KEY, WDCU_KEY_FIRST, 1'b1);
        xfer(1'b1, WDCU_OFS_KEY, WDCU_KEY_SECOND, 1'b0);
    endtask
    initial
    begin
        void'($urandom(67));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(WDCU_OFS_CONTROL, 8'h40, 8'h4B);
        xfer(1'b1, WDCU_OFS_CONTROL, 8'h00, 1'b0);
        rd_chk(WDCU_OFS_CONTROL, 8'h40, 8'h4B);
        repeat (6)
        begin
            d = 8'($urandom());
            xfer(1'b1, WDCU_OFS_IRQ_ENABLE, d, 1'b0);
            rd_chk(WDCU_OFS_IRQ_ENABLE, 8'hE0 | (d & 8'h10), 8'hF0);
        end
        xfer(1'b1, WDCU_OFS_KEY, WDCU_KEY_SECOND, 1'b1);
        xfer(1'b1, WDCU_OFS_KEY, WDCU_KEY_FIRST, 1'b0);
        xfer(1'b1, WDCU_OFS_CONTROL, 8'h00, 1'b0);
        rd_chk(WDCU_OFS_CONTROL, 8'h40, 8'h4B);
        unlock();
        repeat (16) @(posedge pclk);
        xfer(1'b1, WDCU_OFS_CONTROL, 8'h00, 1'b0);
        rd_chk(WDCU_OFS_CONTROL, 8'h40, 8'h4B);
        unlock();
        xfer(1'b1, WDCU_OFS_CONTROL, 8'h02, 1'b0);
        rd_chk(WDCU_OFS_CONTROL, 8'h02, 8'h4B);
        unlock();
        xfer(1'b1, WDCU_OFS_CONTROL, 8'h03, 1'b0);
        rd_chk(WDCU_OFS_CONTROL, 8'h02, 8'h4B);
        xfer(1'b1, WDCU_OFS_IRQ_ENABLE, 8'h10, 1'b0);
        xfer(1'b1, WDCU_OFS_IRQ_PRIORITY, 8'h10, 1'b0);
        xfer(1'b1, WDCU_OFS_EVT_ENABLE, 8'h03, 1'b0);
        lim = 1 << WDCU_INTERVAL_BITS_0;
        t = 0;
        while (dog_irq !== 1'b1 && t < lim + 8)
        begin
            @(negedge pclk);
            t++;
        end
        check(32'(t > lim - 32 && t <= lim), 32'h1);
        check(32'(dog_irq_high_prio), 32'h1);
        t = 0;
        while (dog_reset_out !== 1'b1 && t < 600)
        begin
            @(negedge pclk);
            t++;
        end
        check(t, WDCU_RESET_DELAY_CLK);
        check(32'(evt_irq), 32'h1);
        @(posedge pclk);
        rd_chk(WDCU_OFS_CONTROL, 8'h0C, 8'h0C);
        rd_chk(WDCU_OFS_EVT_STATUS, 8'h03, 8'h03);
        xfer(1'b1, WDCU_OFS_EVT_CLEAR, 8'h03, 1'b0);
        xfer(1'b1, WDCU_OFS_IRQ_ENABLE, 8'h00, 1'b0);
        @(negedge pclk);
        check({30'h0, evt_irq, dog_irq}, 32'h0);
        @(posedge pclk);
        xfer(1'b0, WDCU_OFS_CONTROL, 8'h00, 1'b0);
        d = rdv[7:0];
        ext_reset_pulse <= 1'b1;
        @(posedge pclk);
        ext_reset_pulse <= 1'b0;
        rd_chk(WDCU_OFS_CONTROL, after_ext_reset(d), 8'hFF);
        power_fail_reset_pulse <= 1'b1;
        @(posedge pclk);
        power_fail_reset_pulse <= 1'b0;
        rd_chk(WDCU_OFS_CONTROL, 8'h00, 8'h04);
        xfer(1'b0, 12'h004, 8'h00, 1'b0);
        check(rdv, 32'h0);
        check(32'(errv), 32'h1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(WDCU_OFS_CONTROL, 8'h40, 8'h42);
        tally_and_finish();
    end
endmodule
